// ===== inc/mcf_pkg.sv
/*
 * mcf_pkg: constants, modes and carrier types of the media converter
 * forwarding logic.
 * assumes: one 125 MHz clock domain; frame bytes arrive on that clock.
 */
package mcf_pkg;

  // ----------------------------------------------------------------------
  // ports, lanes and buffering
  // ----------------------------------------------------------------------
  localparam int unsigned NPORT = 3;
  localparam int unsigned NLANE = 3;
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // direction selector positions
  // ----------------------------------------------------------------------
  localparam logic [3:0] SEL_FB_REV = 4'h0;
  localparam logic [3:0] SEL_ETH_LLF_FIRST = 4'h1;
  localparam logic [3:0] SEL_FB_FWD = 4'h5;
  localparam logic [3:0] SEL_ETH_LLF_OPP = 4'h6;
  // no valid position: synchroniser value while in reset
  localparam logic [3:0] SEL_NONE = 4'hf;

  // ----------------------------------------------------------------------
  // frame checking
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_MIN = 64;
  localparam int unsigned FRAME_MAX = 1522;
  localparam int unsigned LEN_W = 11;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned LINK_SETTLE_ETH_NS = 10000;
  localparam int unsigned LINK_SETTLE_ETH_CYC =
    LINK_SETTLE_ETH_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 11;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MCF_MODE_NONE,
    MCF_MODE_ETH,
    MCF_MODE_FB
  } mcf_mode_e;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mcf_byte_s;

  typedef struct packed {
    mcf_mode_e mode;
    logic fwd_first_to_second;
    logic llf_to_first;
    logic mismatch;
    logic [NPORT-1:0] link_up;
  } mcf_diag_s;

endpackage : mcf_pkg

// ===== design/mcf_fifo.sv
/*
 * mcf_fifo: flip-flop FIFO with valid/ready on both sides.
 * assumes: single clock, asynchronous active-low reset.
 */
module mcf_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign s_ready = (cnt_q != (AW+1)'(DEPTH));
  assign m_valid = (cnt_q != '0);
  assign m_data = mem_q[rd_q];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= s_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule : mcf_fifo

// ===== design/mcf_forwarding.sv
/*
 * mcf_forwarding: frame forwarding, link supervision and selector handling
 * of a two- or three-port media converter.
 * assumes: receive bytes, tx_ready and the transmit side run on clk;
 * direction_selector and rx_idle_seen are pins and are synchronised here.
 */

module mcf_forwarding #(
  parameter bit THREE_PORT = 1'b1,
  parameter int unsigned FIFO_DEPTH_P = mcf_pkg::FIFO_DEPTH,
  parameter int unsigned SETTLE_CYC = mcf_pkg::LINK_SETTLE_ETH_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] direction_selector,
  input wire logic [mcf_pkg::NPORT-1:0] rx_idle_seen,
  input wire logic [mcf_pkg::NPORT-1:0] rx_valid,
  input wire mcf_pkg::mcf_byte_s [mcf_pkg::NPORT-1:0] rx_byte,
  input wire logic [mcf_pkg::NPORT-1:0] tx_ready,
  output logic [mcf_pkg::NPORT-1:0] tx_valid,
  output mcf_pkg::mcf_byte_s [mcf_pkg::NPORT-1:0] tx_byte,
  output logic [mcf_pkg::NPORT-1:0] tx_idle_on,
  output logic [mcf_pkg::NPORT-1:0] link_up,
  output mcf_pkg::mcf_diag_s diag,
  output logic status_led
);
  import mcf_pkg::*;

  // ----------------------------------------------------------------------
  // checksum step, reflected, one byte
  // ----------------------------------------------------------------------
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ----------------------------------------------------------------------
  // selector capture
  // ----------------------------------------------------------------------
  typedef enum logic {
    MCF_CFG_WAIT,
    MCF_CFG_RUN
  } mcf_cfg_e;

  mcf_cfg_e cfg_q;
  logic [3:0] sel_s1_q;
  logic [3:0] sel_s2_q;
  logic [3:0] adopted_q;
  logic mismatch_q;
  logic sel_valid;
  logic running;
  logic is_eth;
  logic is_fb;
  logic fb_fwd;
  logic llf_to_first;
  logic ring3;
  logic [1:0] opp;

  assign sel_valid = (sel_s2_q == SEL_FB_REV) || (sel_s2_q == SEL_FB_FWD) ||
                     (sel_s2_q == SEL_ETH_LLF_FIRST) ||
                     (sel_s2_q == SEL_ETH_LLF_OPP);
  assign running = (cfg_q == MCF_CFG_RUN);
  assign is_eth = running && ((adopted_q == SEL_ETH_LLF_FIRST) ||
                              (adopted_q == SEL_ETH_LLF_OPP));
  assign is_fb = running && ((adopted_q == SEL_FB_FWD) ||
                             (adopted_q == SEL_FB_REV));
  assign fb_fwd = (adopted_q == SEL_FB_FWD);
  assign llf_to_first = (adopted_q == SEL_ETH_LLF_FIRST);
  assign ring3 = is_fb && THREE_PORT;
  // opposite side in Ethernet mode is the third port on three-port units
  assign opp = THREE_PORT ? 2'd2 : 2'd1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // invalid code, so nothing is adopted before the pin is synced
      sel_s1_q <= SEL_NONE;
      sel_s2_q <= SEL_NONE;
    end else begin
      sel_s1_q <= direction_selector;
      sel_s2_q <= sel_s1_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= MCF_CFG_WAIT;
      adopted_q <= 4'h0;
      mismatch_q <= 1'b0;
    end else begin
      unique case (cfg_q)
        MCF_CFG_WAIT: begin
          if (sel_valid) begin
            cfg_q <= MCF_CFG_RUN;
            adopted_q <= sel_s2_q;
          end
        end
        MCF_CFG_RUN: begin
          if (sel_s2_q != adopted_q) begin
            mismatch_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // port enables and link supervision
  // ----------------------------------------------------------------------
  logic [NPORT-1:0] port_en;
  logic [NPORT-1:0] link_q;
  logic [NPORT-1:0] force_down;
  logic [NPORT-1:0] tx_idle_on_q;

  assign port_en[0] = running;
  assign port_en[1] = running && (is_fb || !THREE_PORT);
  assign port_en[2] = running && THREE_PORT && (is_fb || is_eth);

  // one direction only: the side the selector names never forces its peer down
  assign force_down[0] = is_eth && llf_to_first &&
                         !link_q[opp];
  assign force_down[1] = is_eth && !llf_to_first && !THREE_PORT &&
                         !link_q[0];
  assign force_down[2] = is_eth && !llf_to_first && THREE_PORT &&
                         !link_q[0];

  for (genvar p = 0; p < NPORT; p++) begin : g_link
    logic idle_s1_q;
    logic idle_s2_q;
    logic [SETTLE_W-1:0] settle_q;
    logic settled;

    assign settled = (settle_q >= SETTLE_W'(SETTLE_CYC));

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        idle_s1_q <= 1'b0;
        idle_s2_q <= 1'b0;
      end else begin
        idle_s1_q <= rx_idle_seen[p];
        idle_s2_q <= idle_s1_q;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        settle_q <= '0;
        link_q[p] <= 1'b0;
        tx_idle_on_q[p] <= 1'b0;
      end else begin
        tx_idle_on_q[p] <= port_en[p] && !force_down[p];
        if (!idle_s2_q || !port_en[p]) begin
          settle_q <= '0;
          link_q[p] <= 1'b0;
        end else if (is_fb) begin
          link_q[p] <= 1'b1;
        end else if (!settled) begin
          settle_q <= settle_q + 1'b1;
        end else begin
          link_q[p] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // lane routing
  // ----------------------------------------------------------------------
  logic [1:0] lane_src [NLANE];
  logic [1:0] lane_dst [NLANE];
  logic [NLANE-1:0] lane_on;

  // ring order follows the selector in fieldbus mode
  assign lane_src[0] = 2'd0;
  assign lane_dst[0] = is_eth ? opp :
                       (ring3 && !fb_fwd) ? 2'd2 : 2'd1;
  assign lane_src[1] = lane_dst[0];
  assign lane_dst[1] = is_eth ? 2'd0 :
                       ring3 ? (fb_fwd ? 2'd2 : 2'd1) : 2'd0;
  assign lane_src[2] = fb_fwd ? 2'd2 : 2'd1;
  assign lane_dst[2] = 2'd0;
  assign lane_on[0] = is_eth || is_fb;
  assign lane_on[1] = is_eth || is_fb;
  assign lane_on[2] = ring3;

  // ----------------------------------------------------------------------
  // lanes: store-and-forward or cut-through into a FIFO
  // ----------------------------------------------------------------------
  logic [NPORT-1:0] take;
  logic [NLANE-1:0] lm_valid;
  mcf_byte_s lm_data [NLANE];

  for (genvar l = 0; l < NLANE; l++) begin : g_lane
    logic [7:0] buf_q [FRAME_MAX];
    logic [LEN_W-1:0] len_q;
    logic [LEN_W-1:0] rd_ptr_q;
    logic [LEN_W-1:0] rd_len_q;
    logic [31:0] crc_q;
    logic full_q;
    logic skip_q;
    logic long_q;
    logic in_v;
    mcf_byte_s in_b;
    logic accept;
    logic [31:0] crc_n;
    logic [LEN_W-1:0] len_n;
    logic good;
    logic fs_valid;
    logic fs_ready;
    mcf_byte_s fs_data;
    mcf_byte_s rd_b;
    logic lm_ready;

    assign in_v = lane_on[l] && rx_valid[lane_src[l]];
    assign in_b = rx_byte[lane_src[l]];
    assign accept = is_eth && in_v && !full_q && !skip_q;
    assign crc_n = crc_step(crc_q, in_b.data);
    assign len_n = len_q + 1'b1;
    assign good = (crc_n == CRC_RESIDUE) && !long_q &&
                  (len_n >= LEN_W'(FRAME_MIN)) &&
                  (len_n <= LEN_W'(FRAME_MAX));
    assign rd_b.data = buf_q[rd_ptr_q];
    assign rd_b.last = (rd_ptr_q == rd_len_q - 1'b1);
    // cut-through in fieldbus mode: fixed latency, no frame wait
    assign fs_valid = is_eth ? full_q : (is_fb && in_v);
    assign fs_data = is_eth ? rd_b : in_b;
    assign lm_ready = lane_on[l] && take[lane_dst[l]];

    always_ff @(posedge clk) begin
      if (accept && !long_q && (len_q != LEN_W'(FRAME_MAX))) begin
        buf_q[len_q] <= in_b.data;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        len_q <= '0;
        crc_q <= CRC_INIT;
        long_q <= 1'b0;
        full_q <= 1'b0;
        skip_q <= 1'b0;
        rd_ptr_q <= '0;
        rd_len_q <= '0;
      end else begin
        // a frame that starts while the buffer is busy is skipped whole
        if (is_eth && in_v && (full_q || skip_q)) begin
          skip_q <= !in_b.last;
        end
        if (accept) begin
          if (in_b.last) begin
            len_q <= '0;
            crc_q <= CRC_INIT;
            long_q <= 1'b0;
            if (good) begin
              full_q <= 1'b1;
              rd_len_q <= len_n;
              rd_ptr_q <= '0;
            end
          end else begin
            crc_q <= crc_n;
            if (len_q == LEN_W'(FRAME_MAX)) begin
              long_q <= 1'b1;
            end else begin
              len_q <= len_n;
            end
          end
        end
        if (is_eth && full_q && fs_ready) begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
          if (rd_b.last) begin
            full_q <= 1'b0;
          end
        end
        if (!running) begin
          full_q <= 1'b0;
        end
      end
    end

    mcf_fifo #(
      .W($bits(mcf_byte_s)),
      .DEPTH(FIFO_DEPTH_P)
    ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .s_valid(fs_valid),
      .s_ready(fs_ready),
      .s_data(fs_data),
      .m_valid(lm_valid[l]),
      .m_ready(lm_ready),
      .m_data(lm_data[l])
    );
  end

  // ----------------------------------------------------------------------
  // transmit stage per port
  // ----------------------------------------------------------------------
  logic [NPORT-1:0] hit;
  mcf_byte_s hit_b [NPORT];
  logic [NPORT-1:0] tx_valid_q;
  mcf_byte_s [NPORT-1:0] tx_byte_q;

  assign take = ~tx_valid_q | tx_ready;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      hit[p] = 1'b0;
      hit_b[p] = '0;
      for (int l = 0; l < NLANE; l++) begin
        if (lane_on[l] && (lane_dst[l] == 2'(p)) && lm_valid[l]) begin
          hit[p] = 1'b1;
          hit_b[p] = lm_data[l];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_valid_q <= '0;
      tx_byte_q <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (take[p]) begin
          tx_valid_q[p] <= hit[p];
          tx_byte_q[p] <= hit_b[p];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // station diagnostics and outputs
  // ----------------------------------------------------------------------
  mcf_diag_s diag_q;
  mcf_diag_s diag_d;
  logic status_led_q;

  assign diag_d.mode = is_fb ? MCF_MODE_FB :
                       is_eth ? MCF_MODE_ETH : MCF_MODE_NONE;
  assign diag_d.fwd_first_to_second = is_fb && fb_fwd;
  assign diag_d.llf_to_first = is_eth && llf_to_first;
  assign diag_d.mismatch = mismatch_q;
  assign diag_d.link_up = link_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      diag_q <= '0;
      status_led_q <= 1'b0;
    end else begin
      diag_q <= diag_d;
      status_led_q <= mismatch_q;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
  assign tx_idle_on = tx_idle_on_q;
  assign link_up = link_q;
  assign diag = diag_q;
  assign status_led = status_led_q;

endmodule : mcf_forwarding

// ===== tb/mcf_forwarding_asserts.sv
/*
 * mcf_fwd_chk: port-level assertions of the forwarding block.
 * assumes: bound into mcf_forwarding; one clock, nrst async active low.
 */
module mcf_fwd_chk #(
  parameter int unsigned SETTLE_CYC = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] direction_selector,
  input wire logic [mcf_pkg::NPORT-1:0] rx_idle_seen,
  input wire logic [mcf_pkg::NPORT-1:0] rx_valid,
  input wire mcf_pkg::mcf_byte_s [mcf_pkg::NPORT-1:0] rx_byte,
  input wire logic [mcf_pkg::NPORT-1:0] tx_ready,
  input wire logic [mcf_pkg::NPORT-1:0] tx_valid,
  input wire mcf_pkg::mcf_byte_s [mcf_pkg::NPORT-1:0] tx_byte,
  input wire logic [mcf_pkg::NPORT-1:0] tx_idle_on,
  input wire logic [mcf_pkg::NPORT-1:0] link_up,
  input wire mcf_pkg::mcf_diag_s diag,
  input wire logic status_led
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire fb = diag.mode == MCF_MODE_FB;
  wire eth = diag.mode == MCF_MODE_ETH;
  wire llf1 = eth && diag.llf_to_first;
  logic [7:0] idle_cnt_q;
  // ----------------------------------------------------------------------
  // cycles of unbroken idle on the first port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idle_cnt_q <= 8'h00;
    else if (!rx_idle_seen[0]) idle_cnt_q <= 8'h00;
    else if (idle_cnt_q != 8'hff) idle_cnt_q <= idle_cnt_q + 8'h01;
  end
  a_idle_fb_all: assert property (fb && $past(fb) |-> tx_idle_on == 3'h7)
    else $error("fieldbus port without idle");
  a_link_loss: assert property ($fell(rx_idle_seen[2]) |-> ##[1:4] !link_up[2])
    else $error("link kept after idle loss");
  a_fb_link_fast: assert property (fb && $rose(rx_idle_seen[1]) |-> ##[1:4] link_up[1])
    else $error("fieldbus link slow to rise");
  a_eth_settle: assert property (eth && $rose(link_up[0]) |-> idle_cnt_q >= SETTLE_CYC)
    else $error("ethernet link up without settling");
  a_llf_first: assert property (llf1 && $past(eth, 2) && $past(!link_up[2]) && $past(!link_up[2], 2) |-> !tx_idle_on[0])
    else $error("first port not taken down");
  a_llf_one_way: assert property (llf1 && $past(eth) |-> tx_idle_on[2] && !tx_idle_on[1])
    else $error("wrong port taken down in ethernet mode");
  a_mode_held: assert property (diag.mode != MCF_MODE_NONE |=> $stable(diag.mode) && $stable(diag.fwd_first_to_second) && $stable(diag.llf_to_first))
    else $error("function changed after adoption");
  a_mismatch_sticky: assert property ($rose(diag.mismatch) |-> ##[0:3] (status_led && diag.mismatch) [*8])
    else $error("mismatch indication not held");
  a_cut_through: assert property (fb && diag.fwd_first_to_second && rx_valid[0] && !tx_valid[1] && tx_ready[1] && $past(tx_ready[1]) |-> ##2 tx_valid[1] && tx_byte[1] == $past(rx_byte[0], 2))
    else $error("cut-through byte late or wrong");
  c_fb_byte: cover property (fb && tx_valid[1] && tx_ready[1]);
  c_eth_byte: cover property (eth && tx_valid[2] && tx_ready[2]);
  c_led: cover property ($rose(status_led));
endmodule : mcf_fwd_chk

bind mcf_forwarding mcf_fwd_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .direction_selector(direction_selector),
  .rx_idle_seen(rx_idle_seen), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_idle_on(tx_idle_on), .link_up(link_up), .diag(diag),
  .status_led(status_led)
);

// ===== tb/mcf_peer.sv
/*
 * mcf_peer: far stations on all three ports.
 * assumes: same clock as the converter; cable_on plugs a station in.
 */
module mcf_peer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] cable_on,
  input wire logic [2:0] slow,
  input wire logic [mcf_pkg::NPORT-1:0] tx_idle_on,
  output logic [mcf_pkg::NPORT-1:0] rx_idle_seen,
  output logic [mcf_pkg::NPORT-1:0] peer_link,
  output logic [mcf_pkg::NPORT-1:0] tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcf_pkg::*;
  logic [NPORT-1:0] tog_q;
  // a plugged station sends idle all the time
  assign rx_idle_seen = cable_on;
  // slow stations accept every other cycle
  assign tx_ready = ~slow | tog_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_q <= '0;
      peer_link <= '0;
    end else begin
      tog_q <= ~tog_q;
      peer_link <= tx_idle_on & cable_on;
    end
  end
endmodule : mcf_peer

// ===== tb/testbench.sv
/*
 * testbench: table of selector rows, then hand tests of frames,
 * link loss forwarding and selector handling.
 * assumes: mcf_peer as far stations; settle count shortened to 4.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcf_pkg::*;
  typedef struct {
    logic [3:0] sel;
    mcf_mode_e mode;
    logic dir;
    logic [2:0] link;
    int dst;
    int len;
  } mcf_tb_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] sel = 4'h3;
  logic [2:0] cable = 3'h0;
  logic [2:0] slow = 3'h0;
  logic [NPORT-1:0] rx_valid = '0;
  mcf_byte_s [NPORT-1:0] rx_byte = '0;
  logic [NPORT-1:0] seen, tx_ready, tx_valid, tx_idle_on, link_up, plink;
  mcf_byte_s [NPORT-1:0] tx_byte;
  mcf_diag_s diag;
  logic status_led;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] frm[$];
  logic [7:0] got[NPORT][$];
  mcf_tb_row_s rows[4] = '{
    '{4'h5, MCF_MODE_FB, 1'b1, 3'h7, 1, 10},
    '{4'h0, MCF_MODE_FB, 1'b0, 3'h7, 2, 10},
    '{4'h1, MCF_MODE_ETH, 1'b1, 3'h5, 2, 64},
    '{4'h6, MCF_MODE_ETH, 1'b0, 3'h5, 2, 64}};

  always #4 clk = ~clk;

  mcf_forwarding #(.THREE_PORT(1'b1), .SETTLE_CYC(4)) DUT (
    .clk(clk), .nrst(nrst), .direction_selector(sel),
    .rx_idle_seen(seen), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_idle_on(tx_idle_on), .link_up(link_up), .diag(diag),
    .status_led(status_led));
  mcf_peer u_peer (
    .clk(clk), .nrst(nrst), .cable_on(cable), .slow(slow),
    .tx_idle_on(tx_idle_on), .rx_idle_seen(seen), .peer_link(plink),
    .tx_ready(tx_ready));

  // collect bytes taken by the far stations
  always @(negedge clk)
    for (int i = 0; i < NPORT; i++)
      if (tx_valid[i] === 1'b1 && tx_ready[i] === 1'b1)
        got[i].push_back(tx_byte[i].data);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(logic [31:0] a, logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      failures++;
      $display("[FAIL] %0t got %0h want %0h", $time, a, e);
    end
  endtask : chk

  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] d);
    c = c ^ {24'h0, d};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction : crc_step

  task automatic boot(logic [3:0] v);
    @(posedge clk);
    nrst <= 1'b0;
    sel <= v;
    cable <= 3'h0;
    slow <= 3'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : boot

  task automatic wt(int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // one frame with its check sequence; bad flips a bit of it
  task automatic xfer(int src, int n, bit good, int dst, bit pass);
    logic [31:0] c;
    c = CRC_INIT;
    frm.delete();
    foreach (got[i]) got[i].delete();
    for (int i = 0; i < n - 4; i++) begin
      frm.push_back(8'(i * 7 + src));
      c = crc_step(c, frm[i]);
    end
    c = ~c;
    for (int i = 0; i < 4; i++)
      frm.push_back(c[8*i+:8] ^ {7'h0, i == 3 && !good});
    foreach (frm[i]) begin
      @(posedge clk);
      rx_valid[src] <= 1'b1;
      rx_byte[src] <= {frm[i], i == n - 1};
    end
    @(posedge clk);
    rx_valid[src] <= 1'b0;
    for (int t = 0; t < 3 * n + 100 && got[dst].size() < n; t++)
      @(posedge clk);
    wt(20);
    chk(got[dst].size(), pass ? n : 0);
    if (pass) chk(got[dst] == frm, 1);
  endtask : xfer

  task automatic end_sim();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  initial begin
    wt(60000);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    foreach (rows[r]) begin
      boot(rows[r].sel);
      chk(diag.mode, rows[r].mode);
      chk(rows[r].mode == MCF_MODE_FB ? diag.fwd_first_to_second
          : diag.llf_to_first, rows[r].dir);
      cable <= 3'h7;
      wt(20);
      chk(link_up, rows[r].link);
      chk(tx_idle_on, rows[r].link);
      chk(diag.link_up, rows[r].link);
      xfer(0, rows[r].len, 1'b1, rows[r].dst, 1'b1);
      $display("row %0d done", r);
    end
    // frame checks and rate adaptation, ethernet position 1
    boot(4'h1);
    cable <= 3'h7;
    wt(20);
    xfer(0, 63, 1'b1, 2, 1'b0);
    xfer(0, 64, 1'b0, 2, 1'b0);
    xfer(0, 1523, 1'b1, 2, 1'b0);
    slow <= 3'h4;
    xfer(0, 1522, 1'b1, 2, 1'b1);
    slow <= 3'h1;
    xfer(2, 64, 1'b1, 0, 1'b1);
    slow <= 3'h0;
    cable[2] <= 1'b0;
    wt(10);
    chk(link_up[2], 0);
    chk(tx_idle_on[0], 0);
    chk(plink[0], 0);
    cable <= 3'h6;
    wt(20);
    chk(tx_idle_on[2], 1);
    $display("ethernet test done");
    // fieldbus lanes and selector moved after adoption
    boot(4'h5);
    cable <= 3'h7;
    wt(20);
    xfer(1, 10, 1'b1, 2, 1'b1);
    xfer(2, 10, 1'b1, 0, 1'b1);
    sel <= 4'h0;
    wt(10);
    chk(diag.fwd_first_to_second, 1);
    chk({status_led, diag.mismatch}, 3);
    xfer(0, 10, 1'b1, 1, 1'b1);
    $display("fieldbus test done");
    // invalid position at power-up
    boot(4'h3);
    chk(diag.mode, MCF_MODE_NONE);
    sel <= 4'h5;
    wt(10);
    chk(diag.mode, MCF_MODE_FB);
    chk(status_led, 0);
    $display("selector test done");
    end_sim();
  end
endmodule : testbench
